//--- hdl/ring_status_pkg.sv
/*
 * Constants and carrier types shared by the ring receive status block.
 * Assumes a Wishbone register bus with 32-bit data and word-aligned registers.
 */
package ring_status_pkg;

   // register byte offsets
   localparam logic [7:0] OFS_CONTROL    = 8'h00;
   localparam logic [7:0] OFS_STATUS_ONE = 8'h04;
   localparam logic [7:0] OFS_STATUS_TWO = 8'h08;
   localparam logic [7:0] OFS_SLOT_ZERO  = 8'h0C;
   localparam logic [7:0] OFS_SLOT_ONE   = 8'h10;
   localparam logic [7:0] OFS_SLOT_TWO   = 8'h14;
   localparam logic [7:0] OFS_SLOT_THREE = 8'h18;
   localparam logic [7:0] OFS_FRAMING    = 8'h1C;

   // receive control register fields
   localparam int CTL_MULTIPROC_BIT   = 0;
   localparam int CTL_ADDR_SELECT_BIT = 2;
   localparam int CTL_RING_ENABLE_BIT = 3;
   localparam int CTL_PARITY_EN_BIT   = 5;
   localparam int CTL_EVEN_PARITY_BIT = 6;
   localparam int CTL_RX_ENABLE_BIT   = 7;
   localparam logic [7:0] CTL_RESET      = 8'h12;
   localparam logic [7:0] CTL_UNUSED_ONE = 8'h12;

   // status register fields
   localparam int ST1_SLOT_ONE_LSB   = 1;
   localparam int ST1_SLOT_TWO_LSB   = 5;
   localparam int ST2_SLOT_THREE_LSB = 1;
   localparam int ST2_POINTER_LSB    = 4;
   localparam logic [7:0] ST1_RESET      = 8'h11;
   localparam logic [7:0] ST1_UNUSED_ONE = 8'h11;
   localparam logic [7:0] ST2_RESET      = 8'hC1;
   localparam logic [7:0] ST2_UNUSED_ONE = 8'hC1;

   // flag order inside a three-bit slot group
   localparam int FLAG_OVERRUN   = 0;
   localparam int FLAG_PARITY    = 1;
   localparam int FLAG_MULTIPROC = 2;
   localparam logic [2:0] FLAGS_RESET = 3'h0;

   localparam logic [1:0] POINTER_RESET = 2'h0;

   typedef struct packed {
      logic [7:0] data;
      logic       parity_bit;
      logic       address_data_marker_bit;
      logic       stop_bit;
   } rx_frame_s;

   typedef struct packed {
      logic [7:0] mode;
      logic [7:0] status_one;
      logic [7:0] status_two;
   } ring_regs_s;

endpackage

//--- hdl/slot_error_flags.sv
/*
 * Three sticky error flags (overrun, parity, multiprocessor) of one receive slot.
 * Assumes set and clear requests come from logic on the same clock.
 */
module slot_error_flags (
   input  wire logic       clock,     // system clock
   input  wire logic       reset,     // synchronous reset, active high
   input  wire logic       set_valid, // frame completed into this slot
   input  wire logic [2:0] set_flags, // errors seen on that frame
   input  wire logic       clr_valid, // software write to the group
   input  wire logic [2:0] clr_keep,  // written value, zero clears
   output logic      [2:0] flags_q    // sticky flags
);
   logic [2:0] keep_mask;
   logic [2:0] set_mask;
   logic [2:0] flags_d;

   assign keep_mask = clr_valid ? clr_keep : 3'h7;
   assign set_mask  = set_valid ? set_flags : 3'h0;
   // set term last so a same-cycle error survives the clear
   assign flags_d   = (flags_q & keep_mask) | set_mask;

   always_ff @(posedge clock) begin
      if (reset) flags_q <= ring_status_pkg::FLAGS_RESET;
      else       flags_q <= flags_d;
   end
endmodule

//--- hdl/rx_ring_store.sv
/*
 * Four receive slots, their unread markers and the ring pointer.
 * Assumes write and read strobes are single-cycle and on the same clock.
 */
module rx_ring_store #(
   parameter int SLOTS  = 4, // ring depth
   parameter int DATA_W = 8  // frame data width
) (
   input  wire logic              clock,      // system clock
   input  wire logic              reset,      // synchronous reset, active high
   input  wire logic              ring_mode,  // ring enabled
   input  wire logic              wr_valid,   // completed frame to store
   input  wire logic [DATA_W-1:0] wr_data,    // frame data
   input  wire logic              rd_valid,   // cpu read of a slot
   input  wire logic [1:0]        rd_slot,    // slot being read
   output logic      [1:0]        target,     // slot the next frame enters
   output logic      [1:0]        pointer_q,  // ring pointer
   output logic      [SLOTS-1:0]  unread_q,   // slot holds unread data
   output logic      [DATA_W-1:0] slot_q [SLOTS] // slot contents
);
   // elaboration-time checks: the pointer and slot decode are two bits wide
   if (SLOTS != 4) $error("rx_ring_store serves exactly four slots");
   if (DATA_W < 1) $error("rx_ring_store needs a data width");

   logic [1:0]       pointer_d;
   logic [SLOTS-1:0] wr_hot;
   logic [SLOTS-1:0] rd_hot;

   function automatic logic [SLOTS-1:0] one_hot(input logic [1:0] idx);
      one_hot = {{(SLOTS-1){1'b0}}, 1'b1} << idx;
   endfunction

   // single-slot mode always lands in slot zero
   assign target    = ring_mode ? pointer_q : 2'h0;
   assign pointer_d = (wr_valid && ring_mode) ? pointer_q + 2'h1 : pointer_q;
   assign wr_hot    = wr_valid ? one_hot(target) : '0;
   assign rd_hot    = rd_valid ? one_hot(rd_slot) : '0;

   always_ff @(posedge clock) begin
      if (reset) pointer_q <= ring_status_pkg::POINTER_RESET;
      else       pointer_q <= pointer_d;
   end

   // a new frame marks the slot unread even if the same slot is read now
   always_ff @(posedge clock) begin
      if (reset) unread_q <= '0;
      else       unread_q <= (unread_q & ~rd_hot) | wr_hot;
   end

   // data is overwritten on overrun; slot contents are undefined after reset
   always_ff @(posedge clock) begin
      for (int i = 0; i < SLOTS; i++) begin
         if (wr_hot[i]) slot_q[i] <= wr_data;
      end
   end
endmodule

//--- hdl/uart_rx_ring_error_status.sv
/*
 * Receive error status of slots one to three and ring pointer of a four-slot UART receiver,
 * with the receive control bits and slot contents, over a classic Wishbone slave.
 * Assumes the receive shifter runs on the same clock and pulses frame_done once
 * per completed frame; all four reset causes are merged into reset upstream.
 */
// The Wishbone interface to the registers and the register offsets were chosen for this implementation.
// Functional notes
// - first status register holds six flags, updated for slots only in ring mode
// - slot one frames update bits 1-3, slot two frames update bits 5-7
// - error flags are sticky; only a software write of zero clears them
// - clearing overrun while data is unread lets the next frame set it again
// - first status register resets to 11H
// - unread slot one on new frame sets overrun bit 1, data still overwritten
// - slot one parity mismatch sets bit 2
// - multiprocessor data receive with marker one sets slot one bit 3
// - slot two has the same three checks in bits 5, 6 and 7
// - slot three errors update second register bits 1-3, sticky
// - unread slot three on new frame sets its overrun bit 1, data loaded
// - slot three parity mismatch sets bit 2, marker error sets bit 3
// - second register bits 4 and 5 show the ring pointer, read-only
// - second status register resets to C1H
// - unimplemented register bits read as one
// - ring mode stores frames in slot order 0,1,2,3,0 with a ready pulse
// - one shared framing flag is set by any accepted frame with a zero stop bit
// - control bit 3 selects single-slot mode at zero, ring mode at one
module uart_rx_ring_error_status (
   input  wire logic                       clock,      // 40 MHz system clock
   input  wire logic                       reset,      // synchronous reset, active high
   input  wire logic                       wb_cyc_i,   // wishbone cycle
   input  wire logic                       wb_stb_i,   // wishbone strobe
   input  wire logic                       wb_we_i,    // wishbone write enable
   input  wire logic [7:0]                 wb_adr_i,   // wishbone byte address
   input  wire logic [3:0]                 wb_sel_i,   // wishbone byte selects
   input  wire logic [31:0]                wb_dat_i,   // wishbone write data
   output logic      [31:0]                wb_dat_o,   // wishbone read data
   output logic                            wb_ack_o,   // wishbone acknowledge
   input  wire logic                       frame_done, // one-cycle frame completion
   input  wire ring_status_pkg::rx_frame_s frame,      // completed frame fields
   output logic                            rx_ready_o  // receive ready pulse
);
   logic        ack_q;
   logic [31:0] rdata_q;
   logic        ready_q;
   logic [7:0]  control_q;
   logic [7:0]  control_d;
   logic        framing_q;
   logic        framing_d;

   logic [2:0]  flags_one;
   logic [2:0]  flags_two;
   logic [2:0]  flags_three;
   logic [1:0]  target;
   logic [1:0]  pointer_q;
   logic [3:0]  unread_q;
   logic [7:0]  slot_q [4];

   // bus request decode
   wire         req        = wb_cyc_i && wb_stb_i && !ack_q;
   wire         wr_req     = req && wb_we_i && wb_sel_i[0];
   wire         rd_req     = req && !wb_we_i;
   wire         hit_ctl    = (wb_adr_i == ring_status_pkg::OFS_CONTROL);
   wire         hit_st1    = (wb_adr_i == ring_status_pkg::OFS_STATUS_ONE);
   wire         hit_st2    = (wb_adr_i == ring_status_pkg::OFS_STATUS_TWO);
   wire         hit_s0     = (wb_adr_i == ring_status_pkg::OFS_SLOT_ZERO);
   wire         hit_s1     = (wb_adr_i == ring_status_pkg::OFS_SLOT_ONE);
   wire         hit_s2     = (wb_adr_i == ring_status_pkg::OFS_SLOT_TWO);
   wire         hit_s3     = (wb_adr_i == ring_status_pkg::OFS_SLOT_THREE);
   wire         hit_frm    = (wb_adr_i == ring_status_pkg::OFS_FRAMING);
   wire         hit_slot   = hit_s0 || hit_s1 || hit_s2 || hit_s3;
   wire [1:0]   rd_slot    = hit_s1 ? 2'h1 : hit_s2 ? 2'h2 : hit_s3 ? 2'h3 : 2'h0;
   wire [7:0]   wbyte      = wb_dat_i[7:0];

   // control bits
   wire ring_mode   = control_q[ring_status_pkg::CTL_RING_ENABLE_BIT];
   wire multiproc   = control_q[ring_status_pkg::CTL_MULTIPROC_BIT];
   wire addr_select = control_q[ring_status_pkg::CTL_ADDR_SELECT_BIT];
   wire parity_en   = control_q[ring_status_pkg::CTL_PARITY_EN_BIT];
   wire even_parity = control_q[ring_status_pkg::CTL_EVEN_PARITY_BIT];
   wire rx_enable   = control_q[ring_status_pkg::CTL_RX_ENABLE_BIT];

   function automatic logic parity_mismatch(input logic [7:0] data, input logic pbit,
                                            input logic even);
      // even parity: data plus parity bit holds an even number of ones
      parity_mismatch = (^{data, pbit}) != !even;
   endfunction

   // frame acceptance; an address frame while receiving data is kept and flagged,
   // a data frame while waiting for an address is ignored entirely
   wire ignored   = multiproc && addr_select && !frame.address_data_marker_bit;
   wire accept    = frame_done && rx_enable && !ignored;
   wire err_ovr   = unread_q[target];
   wire err_par   = parity_en && parity_mismatch(frame.data, frame.parity_bit,
                                                 even_parity);
   wire err_mp    = multiproc && !addr_select && frame.address_data_marker_bit;
   wire [2:0] err_flags = {err_mp, err_par, err_ovr};

   // slot status is recorded only while the ring is enabled
   wire set_one   = accept && ring_mode && (target == 2'h1);
   wire set_two   = accept && ring_mode && (target == 2'h2);
   wire set_three = accept && ring_mode && (target == 2'h3);

   wire wr_st1    = wr_req && hit_st1;
   wire wr_st2    = wr_req && hit_st2;
   wire slot_read = rd_req && hit_slot;

   // status views; pointer bits are never written
   wire [7:0] status_one = ring_status_pkg::ST1_UNUSED_ONE
                         | ({5'h00, flags_one} << ring_status_pkg::ST1_SLOT_ONE_LSB)
                         | ({5'h00, flags_two} << ring_status_pkg::ST1_SLOT_TWO_LSB);
   wire [7:0] status_two = ring_status_pkg::ST2_UNUSED_ONE
                         | ({5'h00, flags_three} << ring_status_pkg::ST2_SLOT_THREE_LSB)
                         | ({6'h00, pointer_q} << ring_status_pkg::ST2_POINTER_LSB);
   wire [7:0] control_view = control_q | ring_status_pkg::CTL_UNUSED_ONE;

   wire [7:0] rd_byte = hit_ctl  ? control_view :
                        hit_st1  ? status_one :
                        hit_st2  ? status_two :
                        hit_slot ? slot_q[rd_slot] :
                        hit_frm  ? {7'h7F, framing_q} : 8'h00;
   // unmapped reads answer zero, unmapped writes are dropped, both acknowledged
   wire [31:0] rd_word = (hit_ctl || hit_st1 || hit_st2 || hit_slot || hit_frm)
                       ? {24'hFFFFFF, rd_byte} : 32'h00000000;

   assign control_d = (wr_req && hit_ctl) ? (wbyte & ~ring_status_pkg::CTL_UNUSED_ONE)
                                          : control_q;
   // shared framing flag: sticky, write zero clears, set wins
   assign framing_d = ((wr_req && hit_frm) ? (framing_q & wbyte[0]) : framing_q)
                    | (accept && !frame.stop_bit);

   slot_error_flags u_flags_one (
      .clock     (clock),
      .reset     (reset),
      .set_valid (set_one),
      .set_flags (err_flags),
      .clr_valid (wr_st1),
      .clr_keep  (wbyte[ring_status_pkg::ST1_SLOT_ONE_LSB +: 3]),
      .flags_q   (flags_one)
   );

   slot_error_flags u_flags_two (
      .clock     (clock),
      .reset     (reset),
      .set_valid (set_two),
      .set_flags (err_flags),
      .clr_valid (wr_st1),
      .clr_keep  (wbyte[ring_status_pkg::ST1_SLOT_TWO_LSB +: 3]),
      .flags_q   (flags_two)
   );

   slot_error_flags u_flags_three (
      .clock     (clock),
      .reset     (reset),
      .set_valid (set_three),
      .set_flags (err_flags),
      .clr_valid (wr_st2),
      .clr_keep  (wbyte[ring_status_pkg::ST2_SLOT_THREE_LSB +: 3]),
      .flags_q   (flags_three)
   );

   rx_ring_store #(
      .SLOTS  (4),
      .DATA_W (8)
   ) u_store (
      .clock     (clock),
      .reset     (reset),
      .ring_mode (ring_mode),
      .wr_valid  (accept),
      .wr_data   (frame.data),
      .rd_valid  (slot_read),
      .rd_slot   (rd_slot),
      .target    (target),
      .pointer_q (pointer_q),
      .unread_q  (unread_q),
      .slot_q    (slot_q)
   );

   always_ff @(posedge clock) begin
      if (reset) begin
         control_q <= ring_status_pkg::CTL_RESET & ~ring_status_pkg::CTL_UNUSED_ONE;
         framing_q <= 1'b0;
      end else begin
         control_q <= control_d;
         framing_q <= framing_d;
      end
   end

   // answer one cycle after the request; ack drops the cycle after it rose
   always_ff @(posedge clock) begin
      if (reset) begin
         ack_q   <= 1'b0;
         rdata_q <= 32'h00000000;
      end else begin
         ack_q   <= req;
         rdata_q <= rd_req ? rd_word : rdata_q;
      end
   end

   always_ff @(posedge clock) begin
      if (reset) ready_q <= 1'b0;
      else       ready_q <= accept;
   end

   assign wb_ack_o   = ack_q;
   assign wb_dat_o   = rdata_q;
   assign rx_ready_o = ready_q;
endmodule

//--- test/frame_source.sv
/* Stand-in for the receive shifter fed by a remote transmitter.
   Assumes the bench calls send right after a rising clock edge; send returns
   one edge after the pulse so back-to-back calls never re-drive in one step. */
module frame_source (
   input  wire logic           clock,      // system clock
   output logic                frame_done, // one-cycle completion
   output ring_status_pkg::rx_frame_s frame // frame fields
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      frame_done = 1'b0;
      frame = '0;
   end
   // bad flips the even parity bit; stop low makes a framing fault
   task automatic send(logic [7:0] d, logic bad, logic mark, logic stop);
      frame_done <= 1'b1;
      frame <= {d, ^d ^ bad, mark, stop};
      @(posedge clock);
      frame_done <= 1'b0;
      // outside a frame the fields are stale: show the inverse, not the value
      frame <= ~{d, ^d ^ bad, mark, stop};
      @(posedge clock);
   endtask
endmodule

//--- test/ring_status_checker.sv
/* Concurrent checks on the bus answer and fixed read bits.
   Assumes it is bound into the top module of the block. */
module ring_status_checker (
   input wire logic        clock,      // system clock
   input wire logic        reset,      // synchronous reset
   input wire logic        wb_cyc_i,   // cycle
   input wire logic        wb_stb_i,   // strobe
   input wire logic        wb_we_i,    // write enable
   input wire logic [7:0]  wb_adr_i,   // byte address
   input wire logic [31:0] wb_dat_o,   // read data
   input wire logic        wb_ack_o,   // acknowledge
   input wire logic        frame_done, // frame pulse
   input wire logic        rx_ready_o  // ready pulse
);
   default clocking cb @(posedge clock); endclocking
   default disable iff (reset);
   sequence req_taken_s;
      wb_cyc_i && wb_stb_i && !wb_ack_o;
   endsequence
   sequence rd_ack_s(logic [7:0] a);
      wb_ack_o && !wb_we_i && wb_adr_i == a;
   endsequence
   ack_follows_req_a: assert property (req_taken_s |=> wb_ack_o)
      else $error("ack missing after request");
   ack_one_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack longer than one cycle");
   ack_has_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
      else $error("ack without request");
   ready_has_frame_a: assert property (rx_ready_o |-> $past(frame_done))
      else $error("ready without frame");
   st_two_fixed_a: assert property (rd_ack_s(ring_status_pkg::OFS_STATUS_TWO) |->
      wb_dat_o[31:8] == 24'hFFFFFF && wb_dat_o[7:6] == 2'h3 && wb_dat_o[0])
      else $error("status two fixed bits wrong");
   st_one_fixed_a: assert property (rd_ack_s(ring_status_pkg::OFS_STATUS_ONE) |->
      &{wb_dat_o[31:8], wb_dat_o[4], wb_dat_o[0]}) else $error("status one fixed bits");
   ctl_fixed_a: assert property (rd_ack_s(ring_status_pkg::OFS_CONTROL) |->
      wb_dat_o[1] && wb_dat_o[4]) else $error("control fixed bits wrong");
   unmapped_zero_a: assert property (wb_ack_o && !wb_we_i && wb_adr_i > 8'h1C
      |-> wb_dat_o == 32'h0) else $error("unmapped read not zero");
endmodule
bind uart_rx_ring_error_status ring_status_checker chk (.clock(clock), .reset(reset),
   .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
   .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .frame_done(frame_done),
   .rx_ready_o(rx_ready_o));

//--- test/uart_rx_ring_error_status_bench.sv
/* Self-checking bench for the ring receive status block.
   Assumes frame_source stands in for the receive shifter. */
module uart_rx_ring_error_status_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] A_CTL = ring_status_pkg::OFS_CONTROL;
   localparam logic [7:0] A_ST1 = ring_status_pkg::OFS_STATUS_ONE;
   localparam logic [7:0] A_ST2 = ring_status_pkg::OFS_STATUS_TWO;
   localparam logic [7:0] A_S0  = ring_status_pkg::OFS_SLOT_ZERO;
   logic        clock = 1'b0;
   logic        reset = 1'b1;
   logic        wb_cyc_i = 1'b0;
   logic        wb_stb_i = 1'b0;
   logic        wb_we_i = 1'b0;
   logic [7:0]  wb_adr_i = 8'h00;
   logic [3:0]  wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o;
   logic        frame_done;
   logic        rx_ready_o;
   logic [31:0] rd;
   int          error_cnt = 0;
   int          check_count = 0;
   ring_status_pkg::rx_frame_s frame;
   always #12.5 clock = ~clock;
   frame_source src (.clock(clock), .frame_done(frame_done), .frame(frame));
   uart_rx_ring_error_status dut (.clock(clock), .reset(reset), .wb_cyc_i(wb_cyc_i),
      .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
      .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
      .frame_done(frame_done), .frame(frame), .rx_ready_o(rx_ready_o));
   task automatic final_report();
      $display("checks %0d mismatches %0d", check_count, error_cnt);
      if (error_cnt == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic wb(logic we, logic [7:0] adr, logic [31:0] dat);
      int n;
      n = 0;
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= dat;
      wb_sel_i <= 4'hF;
      @(posedge clock);
      while (wb_ack_o !== 1'b1) begin
         n++;
         if (n > 20) begin
            error_cnt++;
            final_report();
         end
         @(posedge clock);
      end
      rd = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_sel_i <= 4'h0;
      // one idle cycle keeps the strobe from being re-taken
      @(posedge clock);
   endtask
   task automatic rdchk(string name, logic [7:0] a, logic [31:0] exp);
      wb(1'b0, a, 32'h0);
      check(name, rd, exp);
   endtask
   task automatic t_reset();
      rdchk("status one", A_ST1, 32'hFFFFFF11);
      rdchk("status two", A_ST2, 32'hFFFFFFC1);
      rdchk("control", A_CTL, 32'hFFFFFF12);
      rdchk("framing", ring_status_pkg::OFS_FRAMING, 32'hFFFFFFFE);
      rdchk("unmapped", 8'h20, 32'h0);
      $display("test reset done");
   endtask
   task automatic t_ring();
      wb(1'b1, A_CTL, 32'h88);
      for (int k = 0; k < 4; k++) begin
         src.send(8'hA0 + 8'(k), 1'b0, 1'b0, 1'b1);
         check("ready", {31'h0, rx_ready_o}, 32'h1);
         rdchk("pointer", A_ST2, 32'hFFFFFFC1 | (32'((k + 1) % 4) << 4));
      end
      for (int k = 0; k < 4; k++)
         rdchk("slot data", A_S0 + 8'(4 * k), 32'hFFFFFFA0 + 32'(k));
      $display("test ring order done");
   endtask
   task automatic t_errors();
      wb(1'b1, A_CTL, 32'hE9);
      src.send(8'h11, 1'b0, 1'b0, 1'b1);
      src.send(8'h22, 1'b1, 1'b0, 1'b1);
      src.send(8'h33, 1'b0, 1'b1, 1'b1);
      src.send(8'h44, 1'b1, 1'b1, 1'b1);
      rdchk("status one", A_ST1, 32'hFFFFFF95);
      rdchk("status two", A_ST2, 32'hFFFFFFCD);
      $display("test errors done");
   endtask
   task automatic t_overrun();
      for (int k = 0; k < 4; k++)
         src.send(8'h50 + 8'(k), 1'b0, 1'b0, 1'b1);
      rdchk("status one", A_ST1, 32'hFFFFFFB7);
      rdchk("status two", A_ST2, 32'hFFFFFFCF);
      rdchk("slot one", A_S0 + 8'h04, 32'hFFFFFF51);
      wb(1'b1, A_ST1, 32'h0);
      wb(1'b1, A_ST2, 32'h30);
      rdchk("status one", A_ST1, 32'hFFFFFF11);
      rdchk("status two", A_ST2, 32'hFFFFFFC1);
      for (int k = 0; k < 4; k++)
         src.send(8'h58 + 8'(k), 1'b0, 1'b0, 1'b1);
      rdchk("status one", A_ST1, 32'hFFFFFF31);
      rdchk("status two", A_ST2, 32'hFFFFFFC3);
      src.send(8'h60, 1'b0, 1'b0, 1'b1);
      fork
         wb(1'b1, A_ST1, 32'h0);
         src.send(8'h61, 1'b0, 1'b0, 1'b1);
      join
      rdchk("status one", A_ST1, 32'hFFFFFF13);
      // odd parity; slots two and three are read first, so only slot one gets its overrun back
      wb(1'b1, A_CTL, 32'hA9);
      rdchk("slot two", A_S0 + 8'h08, 32'hFFFFFF5A);
      rdchk("slot three", A_S0 + 8'h0C, 32'hFFFFFF5B);
      wb(1'b1, A_ST2, 32'h0);
      for (int k = 0; k < 4; k++)
         src.send(8'h68 + 8'(k), k != 0, 1'b0, 1'b1);
      rdchk("status one", A_ST1, 32'hFFFFFF53);
      rdchk("status two", A_ST2, 32'hFFFFFFE1);
      $display("test overrun done");
   endtask
   task automatic t_single();
      wb(1'b1, A_CTL, 32'h8D);
      src.send(8'h70, 1'b0, 1'b0, 1'b1);
      check("ready", {31'h0, rx_ready_o}, 32'h0);
      rdchk("pointer", A_ST2, 32'hFFFFFFE1);
      wb(1'b1, A_CTL, 32'hE1);
      src.send(8'h7E, 1'b1, 1'b1, 1'b0);
      rdchk("status one", A_ST1, 32'hFFFFFF53);
      rdchk("status two", A_ST2, 32'hFFFFFFE1);
      rdchk("slot zero", A_S0, 32'hFFFFFF7E);
      wb(1'b0, ring_status_pkg::OFS_FRAMING, 32'h0);
      check("framing", {31'h0, rd[0]}, 32'h1);
      $display("test single mode done");
   endtask
   initial begin
      repeat (4) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      t_reset();
      t_ring();
      t_errors();
      t_overrun();
      t_single();
      // reset again with flags, pointer, framing and control all dirty
      reset <= 1'b1;
      repeat (4) @(posedge clock);
      reset <= 1'b0;
      @(posedge clock);
      t_reset();
      final_report();
   end
endmodule
